//--- rtl/power_reset_pkg.sv
// constants and types for the reset-cause and power-gating block
// assumes a 12-bit byte address on an AXI4-Lite register port
package power_reset_pkg;

  // register byte addresses
  localparam logic [11:0] gate_addr  = 12'hf80;  // peripheral power gate
  localparam logic [11:0] cause_addr = 12'hff0;  // cause (read), watchdog control (write)

  // power gate field positions
  localparam int amp_bit  = 7;  // amplifier off
  localparam int bo_bit   = 4;  // brown-out detector off
  localparam int temp_bit = 3;  // thermal sensor off
  localparam int conv_bit = 2;  // converter off
  localparam int thr_bit  = 1;  // threshold detector off

  // power gate reset value and writable bits
  localparam logic [7:0] gate_reset = 8'h80;
  localparam logic [7:0] gate_mask  = 8'h9e;

  // cause flags {power_on, sleep_recovery, watchdog_expiry, pin_reset}
  localparam logic [3:0] flags_por  = 4'h8;
  localparam logic [3:0] flags_pin  = 4'h1;
  localparam logic [3:0] flags_wsmr = 4'h6;
  localparam logic [3:0] flags_gsmr = 4'h4;
  localparam logic [3:0] flags_none = 4'h0;
  localparam logic [2:0] cause_rsvd = 3'h0;  // reserved bits [3:1]

  // bus response codes
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // power modes
  typedef enum logic [1:0] {
    mode_active,
    mode_halted,
    mode_stopped
  } power_mode_t;

  // reset and recovery event strobes, one cycle each
  typedef struct packed {
    logic debugger_rst;   // debugger control bit reset
    logic debug_pin_low;  // debug pin low (acts in stop only)
    logic brownout_rst;   // brown-out reset
    logic pin_rst;        // external reset pin
    logic wdt_timeout;    // watchdog time-out
    logic gpio_change;    // gpio recovery transition (stop only)
  } wake_evt_t;

  // per-peripheral run enables, high = block may run
  typedef struct packed {
    logic amp;
    logic brownout;
    logic thermal;
    logic converter;
    logic threshold;
  } periph_en_t;

endpackage : power_reset_pkg

//--- rtl/reset_cause_and_power_gating.sv
// reset-cause status, halt/stop sequencing and peripheral power gating
// assumes one 10 MHz clock, strobes synchronous to it, AXI4-Lite master
`timescale 1ns/10ps
`default_nettype none

module reset_cause_and_power_gating
  import power_reset_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // axi4-lite write channels
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // cpu requests and events
  input  wire logic        stop_req,
  input  wire logic        halt_req,
  input  wire logic        irq_pending,
  input  wire wake_evt_t   wake_evt,
  // supply monitor and option straps
  input  wire logic        lvd_cmp,
  input  wire logic        brownout_nonvolatile_option,
  input  wire logic        brownout_stop_option,
  input  wire logic        wdt_reset_mode,
  input  wire logic        wdt_osc_cfg,
  input  wire logic        wdt_enable_cfg,
  // clock and oscillator controls
  output var  logic        sys_clk_en,
  output var  logic        cpu_run,
  output var  logic        primary_osc_en,
  output var  logic        ipo_en,
  output var  logic        ipo_select,
  output var  logic        xtal_pins_gpio,
  output var  logic        wdt_osc_run,
  output var  logic        wdt_count_en,
  output var  power_mode_t power_mode,
  // peripheral enables and watchdog control port
  output var  periph_en_t  periph_en,
  output var  logic        wdt_ctl_wr,
  output var  logic [7:0]  wdt_ctl_data
);

  // reset synchroniser; only the second stage is used
  logic rst_meta_q;
  logic arst_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      arst_n     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      arst_n     <= rst_meta_q;
    end
  end

  // bus holding state
  logic        aw_full_q;   // write address captured
  logic [11:0] awaddr_q;    // captured write address
  logic        w_full_q;    // write data captured
  logic [7:0]  wbyte_q;     // low byte of write data
  logic        wlane_q;     // byte lane 0 enabled

  // block state
  power_mode_t mode_q, mode_d;  // current power mode
  logic [3:0]  flags_q, flags_d; // sticky cause flags
  logic [7:0]  gate_q;           // peripheral power gate

  // handshakes and decode
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire ar_take  = arvalid & arready;
  wire do_write = aw_full_q & w_full_q & ~bvalid;
  wire wr_gate  = do_write & (awaddr_q == gate_addr) & wlane_q;
  wire wr_wdt   = do_write & (awaddr_q == cause_addr) & wlane_q;
  wire wr_hit   = (awaddr_q == gate_addr) | (awaddr_q == cause_addr);
  wire rd_cause = ar_take & (araddr == cause_addr);
  wire rd_gate  = ar_take & (araddr == gate_addr);

  // read data mux; lvd bit is sampled live, reserved bits forced zero
  wire [7:0] cause_view = {flags_q, cause_rsvd, lvd_cmp};
  wire [7:0] rd_byte    = rd_cause ? cause_view :
                          rd_gate  ? gate_q : 8'h00;

  // mode decode
  wire in_stop = (mode_q == mode_stopped);
  wire in_halt = (mode_q == mode_halted);

  // reset-class events that hit the flags
  wire por_like = wake_evt.debugger_rst | wake_evt.brownout_rst |
                  (wake_evt.debug_pin_low & in_stop);
  wire smr_wdt  = wake_evt.wdt_timeout & in_stop;
  wire smr_gpio = wake_evt.gpio_change & in_stop;

  // exit conditions for low-power modes
  wire exit_halt = irq_pending | wake_evt.wdt_timeout |
                   wake_evt.brownout_rst | wake_evt.pin_rst |
                   wake_evt.debugger_rst;
  wire exit_stop = smr_wdt | smr_gpio | wake_evt.pin_rst | por_like;

  // flags with a read clear applied first; events below override it
  wire [3:0] flags_rd = rd_cause ? flags_none : flags_q;

  // event priority: power-on class, pin, then watchdog, then gpio;
  // an event in the read cycle wins over the read clear
  always_comb begin
    flags_d = flags_rd;
    if (por_like) begin
      flags_d = flags_por;
    end else if (wake_evt.pin_rst) begin
      flags_d = flags_pin;
    end else if (smr_wdt) begin
      flags_d = flags_wsmr;
    end else if (wake_evt.wdt_timeout) begin
      // outside stop: sleep and power-on flags drop, pin flag kept
      // unless the watchdog is strapped as a reset source
      flags_d = {2'h0, 1'b1, flags_rd[0] & ~wdt_reset_mode};
    end else if (smr_gpio) begin
      flags_d = flags_gsmr;
    end
  end

  // power mode sequencing
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      mode_active: begin
        if (stop_req) begin
          mode_d = mode_stopped;
        end else if (halt_req) begin
          mode_d = mode_halted;
        end
      end
      mode_halted: begin
        if (exit_halt) begin
          mode_d = mode_active;
        end
      end
      mode_stopped: begin
        if (exit_stop) begin
          mode_d = mode_active;
        end
      end
      default: begin
        mode_d = mode_active;
      end
    endcase
  end

  // the next mode drives the registered clock controls so they match mode_q
  wire nx_stop = (mode_d == mode_stopped);
  wire nx_run  = (mode_d == mode_active);

  // state registers; flags start as power-on
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q  <= mode_active;
      flags_q <= flags_por;
    end else begin
      mode_q  <= mode_d;
      flags_q <= flags_d;
    end
  end

  // power gate: only the power-on reset touches it, other resets
  // are plain strobes and leave it as software set it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= gate_reset;
    end else if (wr_gate) begin
      gate_q <= wbyte_q & gate_mask;
    end
  end

  // clock, oscillator and watchdog controls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sys_clk_en     <= 1'b1;
      cpu_run        <= 1'b1;
      primary_osc_en <= 1'b1;
      ipo_en         <= 1'b1;
      xtal_pins_gpio <= 1'b0;
      wdt_osc_run    <= 1'b1;
      wdt_count_en   <= 1'b0;
      ipo_select     <= 1'b0;
    end else begin
      sys_clk_en     <= ~nx_stop;
      cpu_run        <= nx_run;
      primary_osc_en <= ~nx_stop;
      ipo_en         <= ~nx_stop;
      xtal_pins_gpio <= nx_stop;
      // in stop the rc oscillator follows its setting, else it runs
      wdt_osc_run    <= nx_stop ? wdt_osc_cfg : 1'b1;
      wdt_count_en   <= wdt_enable_cfg;
      // one-cycle pulse: oscillator block forces the ipo back on
      ipo_select     <= in_stop & exit_stop;
    end
  end

  // peripheral enables; a gate bit wins whatever the block requests.
  // amplifier and brown-out may stay alive in stop, the rest idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      periph_en <= '0;
    end else begin
      periph_en.amp       <= ~gate_q[amp_bit];
      periph_en.brownout  <= ~gate_q[bo_bit] & brownout_nonvolatile_option &
                             (~nx_stop | brownout_stop_option);
      periph_en.thermal   <= ~gate_q[temp_bit] & ~nx_stop;
      periph_en.converter <= ~gate_q[conv_bit] & ~nx_stop;
      periph_en.threshold <= ~gate_q[thr_bit] & ~nx_stop;
    end
  end

  // watchdog control writes leave through a one-cycle strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdt_ctl_wr   <= 1'b0;
      wdt_ctl_data <= 8'h00;
    end else begin
      wdt_ctl_wr <= wr_wdt;
      if (wr_wdt) begin
        wdt_ctl_data <= wbyte_q;
      end
    end
  end

  // the mode port is the state register itself, no extra copy
  assign power_mode = mode_q;

  // write address channel: one outstanding write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= 12'h000;
      awready   <= 1'b0;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= awaddr;
      awready   <= 1'b0;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid) begin
      awready   <= 1'b1;
    end
  end

  // write data channel; only byte lane 0 holds register bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      w_full_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
      wready   <= 1'b0;
    end else if (w_take) begin
      w_full_q <= 1'b1;
      wbyte_q  <= wdata[7:0];
      wlane_q  <= wstrb[0];
      wready   <= 1'b0;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid) begin
      wready   <= 1'b1;
    end
  end

  // write response after both halves; unmapped gets slverr
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= resp_okay;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? resp_okay : resp_slverr;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel; data captured on address acceptance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= resp_okay;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_byte};
      rresp   <= (rd_cause | rd_gate) ? resp_okay : resp_slverr;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  wire quiet = ~(|wake_evt);

  sequence s_halt_then_irq;
    in_halt ##0 irq_pending;
  endsequence

  sequence s_stop_gpio;
    in_stop && wake_evt.gpio_change && !wake_evt.pin_rst &&
    !wake_evt.debug_pin_low && !wake_evt.debugger_rst &&
    !wake_evt.brownout_rst && !wake_evt.wdt_timeout;
  endsequence

  a_read_clears: assert property (
    rd_cause && quiet |=> flags_q == flags_none && rdata[7:4] == $past(flags_q))
    else $error("cause read did not clear upper flags");

  a_shared_addr: assert property (
    wr_wdt |=> wdt_ctl_wr && wdt_ctl_data == $past(wbyte_q) && gate_q == $past(gate_q))
    else $error("watchdog write not routed from shared address");

  a_debug_porflags: assert property (
    wake_evt.debugger_rst |=> flags_q == flags_por)
    else $error("debugger reset flags wrong");

  a_gpio_recovery: assert property (
    s_stop_gpio |=> flags_q == flags_gsmr && cpu_run && ipo_select)
    else $error("gpio stop recovery flags or wake wrong");

  a_wdt_recovery: assert property (
    in_stop && wake_evt.wdt_timeout && !por_like && !wake_evt.pin_rst
    |=> flags_q == flags_wsmr)
    else $error("watchdog stop recovery flags wrong");

  a_lvd_live: assert property (
    rd_cause |=> rdata[0] == $past(lvd_cmp) && rdata[3:1] == cause_rsvd)
    else $error("low-supply bit not live");

  a_stop_clocks: assert property (
    in_stop |-> !sys_clk_en && !cpu_run && !ipo_en && xtal_pins_gpio)
    else $error("stop mode left clocks running");

  a_halt_exit: assert property (
    s_halt_then_irq |=> cpu_run && sys_clk_en)
    else $error("halt not left on interrupt");

  a_gate_rsvd: assert property (
    rd_gate |=> (rdata[7:0] & ~gate_mask) == 8'h00)
    else $error("gate reserved bits not zero");

  a_bo_gate: assert property (
    gate_q[bo_bit] |=> !periph_en.brownout)
    else $error("brownout enabled while gated");

endmodule : reset_cause_and_power_gating

`default_nettype wire

//--- test/reset_cause_and_power_gating_tb.sv
// self-checking bench for the reset-cause and power-gating block
// assumes the design package and top module are compiled before it
`timescale 1ns/10ps
`default_nettype none

module reset_cause_and_power_gating_tb;
  import power_reset_pkg::*;

  // bench-driven inputs
  logic        clock, rst_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        stop_req, halt_req, irq_pending, lvd_cmp;
  logic        bo_opt, bo_stop_opt, wdt_rst_mode, wdt_osc_cfg, wdt_en_cfg;
  wake_evt_t   wake_evt;
  // design outputs
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sys_clk_en, cpu_run, primary_osc_en, ipo_en, ipo_select;
  logic        xtal_pins_gpio, wdt_osc_run, wdt_count_en, wdt_ctl_wr;
  logic [7:0]  wdt_ctl_data;
  power_mode_t power_mode;
  periph_en_t  periph_en;
  // bookkeeping
  int          n_mismatch, compares, ipo_cnt, k;
  logic [7:0]  wdt_seen;
  logic [5:0]  halt_exits [5] = '{6'h00, 6'h02, 6'h08, 6'h04, 6'h20};

  reset_cause_and_power_gating i_dut (
    .clock(clock), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .stop_req(stop_req), .halt_req(halt_req),
    .irq_pending(irq_pending), .wake_evt(wake_evt), .lvd_cmp(lvd_cmp),
    .brownout_nonvolatile_option(bo_opt), .brownout_stop_option(bo_stop_opt),
    .wdt_reset_mode(wdt_rst_mode), .wdt_osc_cfg(wdt_osc_cfg),
    .wdt_enable_cfg(wdt_en_cfg), .sys_clk_en(sys_clk_en), .cpu_run(cpu_run),
    .primary_osc_en(primary_osc_en), .ipo_en(ipo_en), .ipo_select(ipo_select),
    .xtal_pins_gpio(xtal_pins_gpio), .wdt_osc_run(wdt_osc_run),
    .wdt_count_en(wdt_count_en), .power_mode(power_mode), .periph_en(periph_en),
    .wdt_ctl_wr(wdt_ctl_wr), .wdt_ctl_data(wdt_ctl_data)
  );

  // 10 MHz system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // capture one-cycle pulses that no bus access can see
  always @(posedge clock) begin
    if (wdt_ctl_wr) wdt_seen <= wdt_ctl_data;
    if (ipo_select) ipo_cnt <= ipo_cnt + 1;
  end

  // single verdict point
  task automatic report_and_stop;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // compare a multi-bit value
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // axi4-lite write: aw and w offered together, bready raised early
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        chk_val(32'(bresp), 32'(er));
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      n_mismatch++;
      report_and_stop();
    end
    // one more edge so registered side effects of the write are visible
    @(posedge clock);
  endtask : wr

  // axi4-lite read with data and response compared
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        chk_val(rdata, exp);
        chk_val(32'(rresp), 32'(er));
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : rd

  // one-cycle event strobe; code zero pulses the interrupt line instead
  task automatic strobe(input logic [5:0] e);
    @(posedge clock);
    if (e == 6'h00) irq_pending <= 1'b1;
    else wake_evt <= wake_evt_t'(e);
    @(posedge clock);
    irq_pending <= 1'b0;
    wake_evt    <= '0;
    repeat (2) @(posedge clock);
  endtask : strobe

  // stop or halt instruction strobe, returns once outputs have settled
  task automatic cpu_op(input logic stop);
    @(posedge clock);
    if (stop) stop_req <= 1'b1;
    else halt_req <= 1'b1;
    @(posedge clock);
    stop_req <= 1'b0;
    halt_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : cpu_op

  // main sequence
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {stop_req, halt_req, irq_pending, lvd_cmp, wake_evt} = '0;
    {bo_opt, bo_stop_opt, wdt_rst_mode, wdt_osc_cfg, wdt_en_cfg} = 5'h1d;
    n_mismatch = 0;
    compares = 0;
    ipo_cnt = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    // power-on state, then read clears the upper flags
    chk_val(32'(periph_en), 32'h0000_000f);
    rd(cause_addr, 32'h0000_0080, resp_okay);
    rd(cause_addr, 32'h0000_0000, resp_okay);
    rd(gate_addr, 32'h0000_0080, resp_okay);
    // gate writes, reserved bits and the brown-out option
    wr(gate_addr, 8'hff, resp_okay);
    rd(gate_addr, 32'h0000_009e, resp_okay);
    chk_val(32'(periph_en), 32'h0000_0000);
    wr(gate_addr, 8'h00, resp_okay);
    chk_val(32'(periph_en), 32'h0000_001f);
    bo_opt <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    chk_bit(periph_en.brownout, 1'b0);
    bo_opt <= 1'b1;
    wr(gate_addr, 8'h0c, resp_okay);
    chk_val(32'(periph_en), 32'h0000_0019);
    // unmapped place is refused
    wr(12'h100, 8'hff, resp_slverr);
    rd(12'h100, 32'h0000_0000, resp_slverr);
    // shared address: writes go to watchdog control only
    wr(cause_addr, 8'ha5, resp_okay);
    chk_val(32'(wdt_seen), 32'h0000_00a5);
    rd(cause_addr, 32'h0000_0000, resp_okay);
    // live low-supply bit survives reads
    lvd_cmp <= 1'b1;
    rd(cause_addr, 32'h0000_0001, resp_okay);
    rd(cause_addr, 32'h0000_0001, resp_okay);
    lvd_cmp <= 1'b0;
    // pin reset, then debugger reset followed by watchdog reset
    strobe(6'h04);
    rd(cause_addr, 32'h0000_0010, resp_okay);
    // reset-mode watchdog after a pin reset drops the pin flag
    strobe(6'h04);
    strobe(6'h02);
    rd(cause_addr, 32'h0000_0020, resp_okay);
    strobe(6'h20);
    strobe(6'h02);
    rd(cause_addr, 32'h0000_0020, resp_okay);
    strobe(6'h20);
    rd(cause_addr, 32'h0000_0080, resp_okay);
    rd(gate_addr, 32'h0000_000c, resp_okay);
    // pin flag and interrupt-mode watchdog flag wiped by a gpio recovery
    wdt_rst_mode <= 1'b0;
    strobe(6'h04);
    strobe(6'h02);
    // interrupt-mode watchdog keeps the pin flag; status read first
    rd(cause_addr, 32'h0000_0030, resp_okay);
    strobe(6'h04);
    strobe(6'h02);
    cpu_op(1'b1);
    chk_val(32'({sys_clk_en, cpu_run, primary_osc_en, ipo_en}), 32'h0);
    chk_bit(xtal_pins_gpio, 1'b1);
    chk_val(32'(power_mode), 32'(mode_stopped));
    chk_bit(wdt_osc_run, wdt_osc_cfg);
    chk_bit(wdt_count_en, 1'b1);
    chk_val(32'(periph_en), 32'h0000_0018);
    k = ipo_cnt;
    strobe(6'h01);
    chk_val(32'(ipo_cnt), 32'(k + 1));
    chk_val(32'(power_mode), 32'(mode_active));
    rd(cause_addr, 32'h0000_0040, resp_okay);
    // watchdog recovery from stop
    cpu_op(1'b1);
    strobe(6'h02);
    rd(cause_addr, 32'h0000_0060, resp_okay);
    // brown-out idle in stop without its option, rc oscillator kept on
    bo_stop_opt <= 1'b0;
    wdt_osc_cfg <= 1'b1;
    cpu_op(1'b1);
    chk_val(32'(periph_en), 32'h0000_0010);
    chk_bit(wdt_osc_run, 1'b1);
    strobe(6'h10);
    rd(cause_addr, 32'h0000_0080, resp_okay);
    bo_stop_opt <= 1'b1;
    wdt_osc_cfg <= 1'b0;
    // halt keeps clocks running and leaves on each listed event
    for (k = 0; k < 5; k++) begin
      cpu_op(1'b0);
      chk_val(32'({sys_clk_en, cpu_run, primary_osc_en, wdt_osc_run}), 32'hb);
      chk_val(32'(power_mode), 32'(mode_halted));
      strobe(halt_exits[k]);
      chk_bit(cpu_run, 1'b1);
      chk_val(32'(power_mode), 32'(mode_active));
    end
    rd(gate_addr, 32'h0000_000c, resp_okay);
    report_and_stop();
  end

endmodule : reset_cause_and_power_gating_tb

`default_nettype wire
